// File: ppm_pkg.sv
//==========================================================
// Behaviour
// - Two-bit power state, 00 full, 11 deepest, resets 00
// - Codes 01 and 10 never taken
// - Unsupported code write completes, value discarded
// - Deepest to full write pulses chip reset only
// - Wake enable bit 8 reads zero
// - Telemetry select bits 12:9 read zero
// - Telemetry scale bits 14:13 read zero
// - Wake status bit 15 reads zero
// - Bit 23 reflects the clock control strap
// - Bit 22 reads one when bit 23 set
// - Strap high in deepest state stops clocks low
// - Strap low keeps secondary clocks running
// - Data byte 31:24 reads zero, writes ignored
// - Reserved bits read-only, return zero
//==========================================================
package ppm_pkg;
    // Configuration dword holding all three registers
    localparam logic [7:0] PPM_DWORD_ADDR = 8'hE0;
    localparam int         PPM_OFS_CSR    = 'hE0;
    localparam int         PPM_OFS_EXT    = 'hE2;
    localparam int         PPM_OFS_DATA   = 'hE3;
    // Power state codes
    localparam logic [1:0] PPM_PS_FULL    = 2'h0;
    localparam logic [1:0] PPM_PS_DEEP    = 2'h3;
    localparam logic [1:0] PPM_PS_RESET   = 2'h0;
    // Field positions
    localparam int         PPM_PS_LSB     = 0;
    localparam int         PPM_CLKSTOP_BIT = 22;
    localparam int         PPM_BPCC_BIT   = 23;
    localparam logic [7:0] PPM_DATA_VALUE = 8'h00;
    // Strap synchroniser depth
    localparam int         PPM_SYNC_LEN   = 3;

    typedef enum logic [1:0] {PPM_IDLE, PPM_RST_PULSE} ppm_rst_type;
endpackage

// File: ppm_csr.sv
`timescale 1ns/1ps
//==========================================================
// Power management control/status dword of the bridge
//==========================================================
module ppm_csr (
    input  wire logic        clk,
    input  wire logic        nrst,
    input  wire logic        cfg_wr,
    input  wire logic        cfg_rd,
    input  wire logic [7:0]  cfg_addr,
    input  wire logic [3:0]  cfg_be_n,
    input  wire logic [31:0] cfg_wdata,
    input  wire logic        strap_clk_ctl,
    output logic      [31:0] cfg_rdata,
    output logic             cfg_rvalid,
    output logic             chip_reset_req,
    output logic             sec_bus_rst_n,
    output logic             sec_clk_en,
    output logic      [1:0]  power_state_field
);

    //==========================================================
    // Strap synchroniser
    //==========================================================
    logic [2:0] strap_sync;
    logic       strap_q;
    logic       next_strap_q;

    // Change accepted only once stages two and three agree
    assign next_strap_q = (strap_sync[1] == strap_sync[2]) ? strap_sync[2] : strap_q;

    always_ff @(posedge clk) begin
        if (!nrst) begin
            strap_sync <= 3'h0;
            strap_q    <= 1'b0;
        end else begin
            strap_sync <= {strap_sync[1:0], strap_clk_ctl};
            strap_q    <= next_strap_q;
        end
    end

    //==========================================================
    // Power state code check
    //==========================================================
    // Shared by the write filter and the state assertion, so
    // both always agree on which codes exist
    function automatic logic ppm_code_ok(input logic [1:0] code);
        return (code == ppm_pkg::PPM_PS_FULL) || (code == ppm_pkg::PPM_PS_DEEP);
    endfunction

    //==========================================================
    // Access decode
    //==========================================================
    wire       hit       = (cfg_addr[7:2] == ppm_pkg::PPM_DWORD_ADDR[7:2]);
    wire       lane0_wr  = cfg_wr && hit && !cfg_be_n[0];
    wire [1:0] wr_code   = cfg_wdata[ppm_pkg::PPM_PS_LSB +: 2];
    // Only full and deepest codes are accepted
    wire       code_ok   = ppm_code_ok(wr_code);
    wire       ps_update = lane0_wr && code_ok;
    wire       wake_up   = ps_update && (wr_code == ppm_pkg::PPM_PS_FULL) &&
                           (power_state_field == ppm_pkg::PPM_PS_DEEP);

    //==========================================================
    // Power state register
    //==========================================================
    logic [1:0] next_ps;
    assign next_ps = ps_update ? wr_code : power_state_field;

    always_ff @(posedge clk) begin
        if (!nrst) begin
            power_state_field <= ppm_pkg::PPM_PS_RESET;
        end else begin
            power_state_field <= next_ps;
        end
    end

    //==========================================================
    // Internal chip reset pulse
    //==========================================================
    ppm_pkg::ppm_rst_type rst_state;
    ppm_pkg::ppm_rst_type next_rst_state;

    // One-cycle pulse; the rest of the chip stretches it as needed
    always_comb begin
        next_rst_state = ppm_pkg::PPM_IDLE;
        case (rst_state)
            ppm_pkg::PPM_IDLE: begin
                if (wake_up) begin
                    next_rst_state = ppm_pkg::PPM_RST_PULSE;
                end
            end
            default: begin
                next_rst_state = ppm_pkg::PPM_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            rst_state <= ppm_pkg::PPM_IDLE;
        end else begin
            rst_state <= next_rst_state;
        end
    end

    assign chip_reset_req = (rst_state == ppm_pkg::PPM_RST_PULSE);
    // Secondary reset is never touched by the power path
    assign sec_bus_rst_n  = 1'b1;

    //==========================================================
    // Secondary clock gating
    //==========================================================
    logic next_clk_en;
    // Clocks stop only with strap high in the deepest state
    // Next strap value used so gating never lags the strap by a cycle
    assign next_clk_en = !(next_strap_q && (next_ps == ppm_pkg::PPM_PS_DEEP));

    always_ff @(posedge clk) begin
        if (!nrst) begin
            sec_clk_en <= 1'b1;
        end else begin
            sec_clk_en <= next_clk_en;
        end
    end

    //==========================================================
    // Read data
    //==========================================================
    wire [15:0] csr_word = {14'h0000, power_state_field};
    // Bit 22 mirrors the strap, so it is one whenever bit 23 is
    wire [7:0]  ext_byte = {strap_q, strap_q, 6'h00};
    wire [31:0] rd_word  = {ppm_pkg::PPM_DATA_VALUE, ext_byte, csr_word};
    wire [31:0] next_rdata = (cfg_rd && hit) ? rd_word : 32'h0000_0000;

    always_ff @(posedge clk) begin
        if (!nrst) begin
            cfg_rdata  <= 32'h0000_0000;
            cfg_rvalid <= 1'b0;
        end else begin
            cfg_rdata  <= next_rdata;
            cfg_rvalid <= cfg_rd;
        end
    end

    //==========================================================
    // Assertions
    //==========================================================
    default clocking ck @(posedge clk); endclocking
    default disable iff (!nrst);

    a_state_legal: assert property (
        ppm_code_ok(power_state_field))
        else $error("power state holds an unsupported code");

    a_bad_code_kept: assert property (
        lane0_wr && !code_ok |=> $stable(power_state_field))
        else $error("unsupported code changed the power state");

    a_good_code_set: assert property (
        lane0_wr && code_ok |=> power_state_field == $past(wr_code))
        else $error("valid code write not applied");

    a_wake_reset: assert property (
        wake_up |=> chip_reset_req ##1 !chip_reset_req)
        else $error("wake write did not give one reset pulse");

    a_no_spurious_rst: assert property (
        chip_reset_req |-> $past(power_state_field) == 2'h3 && power_state_field == 2'h0)
        else $error("chip reset without deepest to full change");

    a_sec_rst_idle: assert property (
        sec_bus_rst_n)
        else $error("secondary reset asserted");

    a_rd_zero_bits: assert property (
        cfg_rvalid |-> cfg_rdata[31:24] == 8'h00 && cfg_rdata[21:2] == 20'h00000)
        else $error("fixed zero field read nonzero");

    a_rd_strap_bits: assert property (
        cfg_rd && hit |=> cfg_rdata[23] == $past(strap_q) && cfg_rdata[22] == cfg_rdata[23])
        else $error("clock control bits do not follow strap");

    a_clk_stopped: assert property (
        strap_q && power_state_field == 2'h3 |-> !sec_clk_en)
        else $error("clocks running in deepest state with strap high");

    a_clk_running: assert property (
        !strap_q |-> sec_clk_en)
        else $error("clocks stopped with strap low");

    //==========================================================
    // Assertions: read path
    //==========================================================
    // Every read strobe gives exactly one valid cycle
    // Host relies on this to pair answers with requests
    a_rvalid_follow: assert property (
        cfg_rd |=> cfg_rvalid)
        else $error("read strobe gave no valid");

    // Valid never stands longer than one cycle per strobe
    // A stuck valid would duplicate answers at the host
    a_rvalid_drop: assert property (
        !cfg_rd |=> !cfg_rvalid)
        else $error("valid without read strobe");

    // Read data returns to zero outside a hitting read
    // Keeps unmapped and idle cycles free of stale data
    a_rdata_idle: assert property (
        !(cfg_rd && hit) |=> cfg_rdata == 32'h0000_0000)
        else $error("read data not zero when idle");

    // State bits of a read show the state at the read edge
    // Catches a read taken from the next value instead
    a_rd_state_bits: assert property (
        cfg_rd && hit |=> cfg_rdata[1:0] == $past(power_state_field))
        else $error("read state bits differ from state");

    //==========================================================
    // Assertions: write path
    //==========================================================
    // Lane zero disabled leaves the state alone
    // Upper lanes carry only read-only fields
    a_lane_off_kept: assert property (
        cfg_wr && hit && cfg_be_n[0] |=> $stable(power_state_field))
        else $error("write without lane zero changed state");

    // Writes to other dwords never reach the state
    // Guards the address compare against wide decoding
    a_miss_kept: assert property (
        cfg_wr && !hit |=> $stable(power_state_field))
        else $error("write to other dword changed state");

    // Without a write the state holds its value
    // Nothing else in the block may move it
    a_idle_kept: assert property (
        !cfg_wr |=> $stable(power_state_field))
        else $error("state changed without a write");

    // A deepest state write lands on the next edge
    // Clock gating depends on this timing
    a_deep_enter: assert property (
        ps_update && wr_code == ppm_pkg::PPM_PS_DEEP |=>
        power_state_field == ppm_pkg::PPM_PS_DEEP)
        else $error("deepest state write not applied");

    //==========================================================
    // Assertions: strap and reset pulse
    //==========================================================
    // Strap accepted once stages two and three agree
    // A single-stage glitch must never reach the register
    a_strap_accept: assert property (
        strap_sync[1] == strap_sync[2] |=> strap_q == $past(strap_sync[2]))
        else $error("agreed strap not accepted");

    // Strap held while the two stages disagree
    // Filters metastable settling on the pin
    a_strap_hold: assert property (
        strap_sync[1] != strap_sync[2] |=> $stable(strap_q))
        else $error("strap moved while stages disagree");

    // Chip reset request is a single cycle
    // Stretching belongs to the chip reset logic
    a_pulse_single: assert property (
        chip_reset_req |=> !chip_reset_req)
        else $error("chip reset longer than one cycle");

    // No reset request without a wake write
    // Other writes must not disturb the chip
    a_no_wake_no_rst: assert property (
        !wake_up |=> !chip_reset_req)
        else $error("chip reset without wake write");

    // Leaving the deepest state restarts the clocks
    // Secondary devices need clocks to see the reset
    a_clk_wake: assert property (
        wake_up |=> sec_clk_en)
        else $error("clocks still stopped after wake");

    // Gating always matches strap and state together
    // Ties the register to both inputs at every edge
    a_clk_follow: assert property (
        sec_clk_en == !(strap_q && power_state_field == ppm_pkg::PPM_PS_DEEP))
        else $error("clock gating out of step with state");

    c_enter_deep: cover property (lane0_wr && wr_code == 2'h3 ##1 !sec_clk_en);
    c_wake_up: cover property (wake_up ##1 chip_reset_req);
    c_bad_write: cover property (lane0_wr && !code_ok);
    c_lane_off: cover property (cfg_wr && hit && cfg_be_n[0]);

endmodule // ppm_csr

// File: ppm_cfg_host.sv
`timescale 1ns/1ps
//==========================================================
// Configuration host model on the primary side
//==========================================================
module ppm_cfg_host (
    input  wire logic        clk,
    output logic             cfg_wr,
    output logic             cfg_rd,
    output logic      [7:0]  cfg_addr,
    output logic      [3:0]  cfg_be_n,
    output logic      [31:0] cfg_wdata
);
    // Idle bus at time zero
    initial begin
        cfg_wr    = 1'b0;
        cfg_rd    = 1'b0;
        cfg_addr  = 8'h00;
        cfg_be_n  = 4'hF;
        cfg_wdata = 32'h0000_0000;
    end

    // One-cycle strobe; released address and data are scrambled so stale data is never seen
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [3:0] be_n,
                        input logic [31:0] d);
        @(negedge clk);
        cfg_wr    <= wr;
        cfg_rd    <= !wr;
        cfg_addr  <= a;
        cfg_be_n  <= be_n;
        cfg_wdata <= d;
        @(negedge clk);
        cfg_wr    <= 1'b0;
        cfg_rd    <= 1'b0;
        cfg_addr  <= ~a;
        cfg_wdata <= ~d;
    endtask
endmodule // ppm_cfg_host

// File: ppm_csr_tb_top.sv
`timescale 1ns/1ps
//==========================================================
// Testbench top
//==========================================================
module ppm_csr_tb_top;
    logic        clk;
    logic        nrst;
    logic        strap;
    logic        cfg_wr, cfg_rd, cfg_rvalid, chip_reset_req, sec_bus_rst_n, sec_clk_en;
    logic [7:0]  cfg_addr;
    logic [3:0]  cfg_be_n;
    logic [31:0] cfg_wdata, cfg_rdata;
    logic [1:0]  power_state_field;
    logic [31:0] exp_q[$];
    logic [31:0] lfsr = 32'hD626C281;
    int          failures = 0;
    int          samples_checked = 0;

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    ppm_cfg_host host (.clk(clk), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd), .cfg_addr(cfg_addr),
                       .cfg_be_n(cfg_be_n), .cfg_wdata(cfg_wdata));
    ppm_csr dut (.clk(clk), .nrst(nrst), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd),
                 .cfg_addr(cfg_addr), .cfg_be_n(cfg_be_n), .cfg_wdata(cfg_wdata),
                 .strap_clk_ctl(strap), .cfg_rdata(cfg_rdata), .cfg_rvalid(cfg_rvalid),
                 .chip_reset_req(chip_reset_req), .sec_bus_rst_n(sec_bus_rst_n),
                 .sec_clk_en(sec_clk_en), .power_state_field(power_state_field));

    //==========================================================
    // Helpers
    //==========================================================
    function automatic logic [31:0] rnd();
        lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
        return lfsr;
    endfunction

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Random upper bits hit every read-only field
    task automatic wr(input logic [3:0] be_n, input logic [1:0] code);
        logic [31:0] r;
        r = rnd();
        host.xfer(1'b1, ppm_pkg::PPM_DWORD_ADDR, be_n, {r[31:2], code});
    endtask

    // Expected dword noted before the read goes out
    task automatic rd(input logic [1:0] ps, input logic s);
        exp_q.push_back({8'h00, s, s, 6'h00, 14'h0000, ps});
        host.xfer(1'b0, ppm_pkg::PPM_DWORD_ADDR, 4'h0, rnd());
    endtask

    task automatic finish_test();
        $display("failures=%0d samples_checked=%0d", failures, samples_checked);
        if (failures == 0 && samples_checked > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask

    // Read monitor: oldest note against each returned dword
    always @(negedge clk) begin
        if (cfg_rvalid === 1'b1) check(cfg_rdata, exp_q.size() ? exp_q.pop_front() : 'x);
    end

    //==========================================================
    // Scenarios
    //==========================================================
    initial begin
        nrst  = 1'b0;
        strap = 1'b0;
        repeat (6) @(posedge clk);
        @(negedge clk) nrst = 1'b1;
        rd(2'h0, 1'b0);
        wr(4'h0, ppm_pkg::PPM_PS_DEEP);
        check(sec_clk_en, 1);
        check(power_state_field, ppm_pkg::PPM_PS_DEEP);
        rd(2'h3, 1'b0);
        for (int c = 1; c < 3; c++) wr(4'h0, 2'(c));
        wr(4'hF, 2'h0);
        rd(2'h3, 1'b0);
        wr(4'h0, ppm_pkg::PPM_PS_FULL);
        check({sec_bus_rst_n, chip_reset_req}, 2'h3);
        @(negedge clk) check(chip_reset_req, 0);
        strap = 1'b1;
        repeat (6) @(negedge clk);
        rd(2'h0, 1'b1);
        wr(4'hE, ppm_pkg::PPM_PS_DEEP);
        check(sec_clk_en, 0);
        rd(2'h3, 1'b1);
        wr(4'h0, ppm_pkg::PPM_PS_FULL);
        check(sec_clk_en, 1);
        repeat (3) @(negedge clk);
        finish_test();
    end

    // Watchdog, far beyond the roughly 40 cycles above
    initial begin
        repeat (2000) @(posedge clk);
        failures++;
        finish_test();
    end
endmodule // ppm_csr_tb_top
